// ==== hw/ofr_fault_response.sv ====
// fault response logic for output overcurrent and die overtemperature
// ------------------------------------------------------------
// fault response top
// ------------------------------------------------------------
// Functional notes
// RQ1: overcurrent fault sets none-of-above, summary, current word bit, iout fault bit
// RQ2: any overcurrent or overtemperature fault bit set raises host attention line
// RQ3: each response command carries exactly one data byte per transaction
// RQ4: response 00 keeps running, limiting current indefinitely
// RQ5: response 10 limits for delay time, then acts on retry field
// RQ6: response 11 shuts output down at once, then follows retry
// RQ7: retry 000 never restarts until enable cycled or bias lost
// RQ8: retry 111 restarts endlessly until commanded off or other fault
// RQ9: restart spacing comes from the restart interval setting
// RQ10: delay field counts 16 ms units, only for deglitched-off response
// RQ11: fault bits clear only by clear command, off-on cycle, or bias loss
// RQ12: overtemperature sets none-of-above, mfr word bit, mfr overtemp bit
// RQ13: overtemperature response 00 or 01 is refused with bad command fault
// RQ14: overtemperature response 10 disables output then follows retry
// RQ15: overtemperature response 11 disables only while fault persists
// RQ16: overtemperature retry other than 000 raises bad command fault
// RQ17: overtemperature delay field is ignored
// RQ18: overtemperature response byte is read only, default c0
// RQ19: overcurrent response byte at code 47, read/write, default 00
// RQ20: overcurrent response 01 write refused, bad command, value kept
module ofr_fault_response (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_write,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_byte_count_ok,
  input wire logic clear_faults,
  input wire logic output_on_cmd,
  input wire logic oc_detect,
  input wire logic ot_detect,
  input wire logic [31:0] restart_interval_setting,
  output logic [7:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic bad_command_fault,
  output logic host_attention,
  output logic output_enable,
  output logic current_limit_active,
  output ofr_pkg::ofr_status_t status
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic oc_byte_ok(input logic [7:0] b);
    return b[ofr_pkg::RESP_HI:ofr_pkg::RESP_LO] != ofr_pkg::RESP_UNSUPPORTED;
  endfunction : oc_byte_ok

  logic [7:0] overcurrent_reaction_byte_reg;
  logic [7:0] die_overheat_reaction_byte_reg;
  logic oc_fault_reg;
  logic ot_fault_reg;
  logic on_prev_reg;
  ofr_pkg::ofr_oc_state_t oc_state_reg;
  logic ot_latched_reg;

  logic wr_oc;
  logic wr_ot;
  logic on_rise;
  logic fault_clear;
  logic [1:0] oc_resp;
  logic [2:0] oc_retry;
  logic [1:0] ot_resp;
  logic oc_new;
  logic ot_new;
  logic delay_load;
  logic delay_run;
  logic delay_done;
  logic retry_load;
  logic retry_done;
  logic retry_done_raw;
  logic [31:0] delay_value;

  // one byte per command; a wrong count is refused  [RQ3]
  assign wr_oc = cmd_write && cmd_byte_count_ok && cmd_code == ofr_pkg::CMD_OC_REACTION;
  assign wr_ot = cmd_write && cmd_byte_count_ok && cmd_code == ofr_pkg::CMD_OT_REACTION;
  assign on_rise = output_on_cmd && !on_prev_reg;
  assign fault_clear = clear_faults || on_rise; // [RQ11]
  assign oc_resp = overcurrent_reaction_byte_reg[ofr_pkg::RESP_HI:ofr_pkg::RESP_LO];
  assign oc_retry = overcurrent_reaction_byte_reg[ofr_pkg::RETRY_HI:ofr_pkg::RETRY_LO];
  assign ot_resp = die_overheat_reaction_byte_reg[ofr_pkg::RESP_HI:ofr_pkg::RESP_LO];
  assign oc_new = oc_detect && !oc_fault_reg;
  assign ot_new = ot_detect && !ot_fault_reg;

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overcurrent_reaction_byte_reg <= ofr_pkg::OC_REACTION_RESET; // [RQ19]
    end else if (wr_oc && oc_byte_ok(cmd_wdata)) begin
      overcurrent_reaction_byte_reg <= cmd_wdata; // [RQ19] [RQ20]
    end
  end

  // read only: writes never land, the default is fixed  [RQ18]
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      die_overheat_reaction_byte_reg <= ofr_pkg::OT_REACTION_RESET;
    end else begin
      die_overheat_reaction_byte_reg <= ofr_pkg::OT_REACTION_RESET;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_rdata <= 8'h00;
      cmd_rvalid <= 1'b0;
    end else begin
      cmd_rvalid <= cmd_read && (cmd_code == ofr_pkg::CMD_OC_REACTION ||
                                 cmd_code == ofr_pkg::CMD_OT_REACTION);
      if (cmd_read && cmd_code == ofr_pkg::CMD_OC_REACTION) begin
        cmd_rdata <= overcurrent_reaction_byte_reg; // [RQ3]
      end else if (cmd_read && cmd_code == ofr_pkg::CMD_OT_REACTION) begin
        cmd_rdata <= die_overheat_reaction_byte_reg; // [RQ3]
      end else begin
        cmd_rdata <= 8'h00;
      end
    end
  end

  // bad command: sticky, set wins over clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bad_command_fault <= 1'b0;
    end else if (wr_oc && !oc_byte_ok(cmd_wdata)) begin
      bad_command_fault <= 1'b1; // [RQ20]
    end else if (wr_ot && (cmd_wdata[ofr_pkg::RESP_HI] == 1'b0 ||
                 cmd_wdata[ofr_pkg::RETRY_HI:ofr_pkg::RETRY_LO] != ofr_pkg::RETRY_NONE)) begin
      bad_command_fault <= 1'b1; // [RQ13] [RQ16]
    end else if (wr_ot) begin
      bad_command_fault <= 1'b1; // [RQ18]
    end else if (clear_faults) begin
      bad_command_fault <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // fault bits and status
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      on_prev_reg <= 1'b0;
    end else begin
      on_prev_reg <= output_on_cmd;
    end
  end

  // bias loss is the reset itself; detection wins over clearing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oc_fault_reg <= 1'b0;
      ot_fault_reg <= 1'b0;
    end else begin
      if (oc_detect) begin
        oc_fault_reg <= 1'b1;
      end else if (fault_clear) begin
        oc_fault_reg <= 1'b0; // [RQ11]
      end
      if (ot_detect) begin
        ot_fault_reg <= 1'b1;
      end else if (fault_clear) begin
        ot_fault_reg <= 1'b0; // [RQ11]
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      host_attention <= 1'b0;
    end else begin
      status.none_of_above <= oc_fault_reg || ot_fault_reg; // [RQ1] [RQ12]
      status.overcurrent_summary_bit <= oc_fault_reg; // [RQ1]
      status.word_current <= oc_fault_reg; // [RQ1]
      status.output_oc_fault <= oc_fault_reg; // [RQ1]
      status.word_mfr <= ot_fault_reg; // [RQ12]
      status.mfr_overtemp <= ot_fault_reg; // [RQ12]
      host_attention <= oc_fault_reg || ot_fault_reg || bad_command_fault; // [RQ2]
    end
  end

  // ------------------------------------------------------------
  // overcurrent reaction sequencer
  // ------------------------------------------------------------
  assign delay_value = 32'(ofr_pkg::DELAY_UNIT_CYC) *
                       32'(overcurrent_reaction_byte_reg[ofr_pkg::DELAY_HI:ofr_pkg::DELAY_LO]);
  assign delay_load = oc_state_reg == ofr_pkg::OC_IDLE; // [RQ10]
  assign delay_run = oc_state_reg == ofr_pkg::OC_LIMIT && oc_resp == ofr_pkg::RESP_DEGLITCH_OFF;
  assign retry_load = oc_state_reg != ofr_pkg::OC_WAIT;
  // a zero interval still costs one cycle, so restarts never chatter
  assign retry_done = retry_done_raw;

  ofr_tick_counter #(.WIDTH(32)) u_delay (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(delay_load),
    .load_value(delay_value),
    .run(delay_run),
    .expired(delay_done)
  );

  ofr_tick_counter #(.WIDTH(32)) u_retry (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(retry_load),
    .load_value(restart_interval_setting),
    .run(oc_state_reg == ofr_pkg::OC_WAIT),
    .expired(retry_done_raw)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oc_state_reg <= ofr_pkg::OC_IDLE;
    end else begin
      case (oc_state_reg)
        ofr_pkg::OC_IDLE: begin
          if (oc_detect && output_on_cmd) begin
            if (oc_resp == ofr_pkg::RESP_SHUT_NOW) begin
              oc_state_reg <= ofr_pkg::OC_OFF; // [RQ6]
            end else begin
              oc_state_reg <= ofr_pkg::OC_LIMIT; // [RQ4] [RQ5]
            end
          end
        end
        ofr_pkg::OC_LIMIT: begin
          if (!oc_detect) begin
            oc_state_reg <= ofr_pkg::OC_IDLE;
          end else if (delay_done) begin
            oc_state_reg <= ofr_pkg::OC_OFF; // [RQ5] [RQ10]
          end
        end
        ofr_pkg::OC_OFF: begin
          if (!output_on_cmd) begin
            oc_state_reg <= ofr_pkg::OC_IDLE; // [RQ7] [RQ8]
          end else if (oc_retry == ofr_pkg::RETRY_FOREVER && !ot_latched_reg) begin
            oc_state_reg <= ofr_pkg::OC_WAIT; // [RQ8]
          end
        end
        ofr_pkg::OC_WAIT: begin
          if (!output_on_cmd || ot_latched_reg) begin
            oc_state_reg <= ofr_pkg::OC_OFF; // [RQ8]
          end else if (retry_done) begin
            oc_state_reg <= ofr_pkg::OC_IDLE; // [RQ9]
          end
        end
        default: begin
          oc_state_reg <= ofr_pkg::OC_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // overtemperature reaction; delay field never read  [RQ17]
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ot_latched_reg <= 1'b0;
    end else if (ot_detect && ot_resp == ofr_pkg::OT_RESP_LATCH_OFF) begin
      ot_latched_reg <= 1'b1; // [RQ14] [RQ16]
    end else if (on_rise || !output_on_cmd) begin
      ot_latched_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      output_enable <= 1'b0;
      current_limit_active <= 1'b0;
    end else begin
      output_enable <= output_on_cmd && !ot_latched_reg && !ot_detect && // [RQ14] [RQ15]
                       oc_state_reg != ofr_pkg::OC_OFF && oc_state_reg != ofr_pkg::OC_WAIT;
      current_limit_active <= oc_state_reg == ofr_pkg::OC_LIMIT; // [RQ4]
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_oc_status_set: assert property (@(posedge sys_clk) disable iff (rst) // [RQ1]
    oc_detect |-> ##2 (status.output_oc_fault && status.overcurrent_summary_bit))
    else $error("overcurrent status not set");
  a_attention_raise: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
    (ot_detect || oc_detect) |-> ##2 host_attention)
    else $error("attention line not raised");
  a_ot_status_set: assert property (@(posedge sys_clk) disable iff (rst) // [RQ12]
    ot_detect |-> ##2 (status.mfr_overtemp && status.word_mfr && status.none_of_above))
    else $error("overtemperature status not set");
  a_shut_now: assert property (@(posedge sys_clk) disable iff (rst) // [RQ6]
    (oc_state_reg == ofr_pkg::OC_IDLE && oc_detect && output_on_cmd &&
     oc_resp == ofr_pkg::RESP_SHUT_NOW) |-> ##2 !output_enable)
    else $error("immediate shutdown missed");
  a_limit_hold: assert property (@(posedge sys_clk) disable iff (rst) // [RQ4]
    (oc_state_reg == ofr_pkg::OC_LIMIT && oc_resp == ofr_pkg::RESP_LIMIT_FOREVER &&
     oc_detect) |=> oc_state_reg == ofr_pkg::OC_LIMIT)
    else $error("limit mode left while fault present");
  a_no_restart: assert property (@(posedge sys_clk) disable iff (rst) // [RQ7]
    (oc_state_reg == ofr_pkg::OC_OFF && oc_retry == ofr_pkg::RETRY_NONE && output_on_cmd)
    |=> oc_state_reg == ofr_pkg::OC_OFF)
    else $error("restart without retry");
  a_bad_oc_write: assert property (@(posedge sys_clk) disable iff (rst) // [RQ20]
    (wr_oc && !oc_byte_ok(cmd_wdata)) |=>
      (bad_command_fault && $stable(overcurrent_reaction_byte_reg)))
    else $error("unsupported response accepted");
  a_ot_readonly: assert property (@(posedge sys_clk) disable iff (rst) // [RQ18]
    die_overheat_reaction_byte_reg == ofr_pkg::OT_REACTION_RESET)
    else $error("overtemperature byte changed");
  a_ot_auto: assert property (@(posedge sys_clk) disable iff (rst) // [RQ15]
    ot_detect |=> !output_enable)
    else $error("output enabled during overtemperature");
  a_ot_refused: assert property (@(posedge sys_clk) disable iff (rst) // [RQ13] [RQ16]
    wr_ot |=> bad_command_fault)
    else $error("overtemperature write not refused");
  a_deglitch_expire: assert property (@(posedge sys_clk) disable iff (rst) // [RQ5]
    (oc_state_reg == ofr_pkg::OC_LIMIT && oc_resp == ofr_pkg::RESP_DEGLITCH_OFF &&
     oc_detect && delay_done) |=> oc_state_reg == ofr_pkg::OC_OFF)
    else $error("deglitched response did not shut down");
  a_retry_forever: assert property (@(posedge sys_clk) disable iff (rst) // [RQ8]
    (oc_state_reg == ofr_pkg::OC_OFF && oc_retry == ofr_pkg::RETRY_FOREVER &&
     output_on_cmd && !ot_latched_reg) |=> oc_state_reg == ofr_pkg::OC_WAIT)
    else $error("endless retry not started");
  a_retry_spacing: assert property (@(posedge sys_clk) disable iff (rst) // [RQ9]
    (oc_state_reg == ofr_pkg::OC_WAIT && output_on_cmd && !ot_latched_reg &&
     !retry_done) |=> oc_state_reg == ofr_pkg::OC_WAIT)
    else $error("restart before interval elapsed");
  a_fault_sticky: assert property (@(posedge sys_clk) disable iff (rst) // [RQ11]
    (oc_fault_reg && !fault_clear) |=> oc_fault_reg)
    else $error("overcurrent fault bit dropped");
  c_oc_shutdown: cover property (@(posedge sys_clk) disable iff (rst)
    oc_state_reg == ofr_pkg::OC_LIMIT ##1 oc_state_reg == ofr_pkg::OC_OFF);
  c_oc_retry: cover property (@(posedge sys_clk) disable iff (rst)
    oc_state_reg == ofr_pkg::OC_WAIT ##1 oc_state_reg == ofr_pkg::OC_IDLE);
  c_bad_cmd: cover property (@(posedge sys_clk) disable iff (rst) $rose(bad_command_fault));
  c_oc_first: cover property (@(posedge sys_clk) disable iff (rst) oc_new);
  c_ot_first: cover property (@(posedge sys_clk) disable iff (rst) ot_new);

endmodule : ofr_fault_response

// ==== inc/ofr_pkg.sv ====
// shared constants and types for the overcurrent / overtemperature fault response block
package ofr_pkg;

  // ------------------------------------------------------------
  // command codes and register layout
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_OC_REACTION = 8'h47;
  localparam logic [7:0] CMD_OT_REACTION = 8'hd6;
  localparam logic [7:0] OC_REACTION_RESET = 8'h00;
  localparam logic [7:0] OT_REACTION_RESET = 8'hc0;
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;

  localparam logic [1:0] RESP_LIMIT_FOREVER = 2'h0;
  localparam logic [1:0] RESP_UNSUPPORTED = 2'h1;
  localparam logic [1:0] RESP_DEGLITCH_OFF = 2'h2;
  localparam logic [1:0] RESP_SHUT_NOW = 2'h3;
  localparam logic [1:0] OT_RESP_LATCH_OFF = 2'h2;
  localparam logic [1:0] OT_RESP_AUTO_RESUME = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 125000000;
  localparam longint DELAY_UNIT_MS = 16;
  localparam longint DELAY_UNIT_CYC = (CLK_HZ * DELAY_UNIT_MS) / 1000;

  // ------------------------------------------------------------
  // status carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic none_of_above;
    logic overcurrent_summary_bit;
    logic word_current;
    logic word_mfr;
    logic output_oc_fault;
    logic mfr_overtemp;
  } ofr_status_t;

  typedef enum logic [3:0] {
    OC_IDLE = 4'h1,
    OC_LIMIT = 4'h2,
    OC_OFF = 4'h4,
    OC_WAIT = 4'h8
  } ofr_oc_state_t;

endpackage : ofr_pkg

// ==== hw/ofr_tick_counter.sv ====
// reloadable down counter that times delays in clock cycles
module ofr_tick_counter #(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic run,
  output logic expired
);

  logic [WIDTH-1:0] count_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= load_value;
    end else if (run && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign expired = run && !load && (count_reg == '0);

endmodule : ofr_tick_counter

// ==== testbench/ofr_host_model.sv ====
// host-side model: single-byte response commands, clear and on/off controls
module ofr_host_model (
  input wire logic sys_clk,
  output logic cmd_write,
  output logic cmd_read,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata,
  output logic cmd_byte_count_ok,
  output logic clear_faults,
  output logic output_on_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_write = 1'b0;
    cmd_read = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
    cmd_byte_count_ok = 1'b1;
    clear_faults = 1'b0;
    output_on_cmd = 1'b1;
  end

  // one data byte per command; called just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data,
                      input logic one_byte);
    cmd_code = code;
    cmd_wdata = data;
    cmd_byte_count_ok = one_byte;
    cmd_write = wr;
    cmd_read = ~wr;
    @(posedge sys_clk);
    #1;
    cmd_write = 1'b0;
    cmd_read = 1'b0;
    // stale bus values must not look valid after release
    cmd_code = ~code;
    cmd_wdata = ~data;
    // idle edge so a following call never re-drives a strobe in the same step
    @(posedge sys_clk);
    #1;
  endtask : xfer

  task automatic pulse_clear();
    clear_faults = 1'b1;
    @(posedge sys_clk);
    #1;
    clear_faults = 1'b0;
  endtask : pulse_clear

  task automatic cycle_on();
    output_on_cmd = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    output_on_cmd = 1'b1;
  endtask : cycle_on
endmodule : ofr_host_model

// ==== testbench/tb_top.sv ====
// self-checking bench for the fault response block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] OC = ofr_pkg::CMD_OC_REACTION;
  localparam logic [7:0] OT = ofr_pkg::CMD_OT_REACTION;
  localparam logic [7:0] OT_WR[4] = '{8'h00, 8'h7f, 8'h88, 8'hf8};
  logic sys_clk, rst, cmd_write, cmd_read, cmd_byte_count_ok, clear_faults, output_on_cmd;
  logic oc_detect, ot_detect, cmd_rvalid, bad_command_fault, host_attention;
  logic output_enable, current_limit_active;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata, rnd;
  logic [31:0] restart_interval_setting;
  ofr_pkg::ofr_status_t status;
  logic [7:0] exp_q[$];
  int num_errors, checked;
  integer seed;

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  ofr_fault_response dut (.sys_clk(sys_clk), .rst(rst), .cmd_write(cmd_write),
    .cmd_read(cmd_read), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_byte_count_ok(cmd_byte_count_ok), .clear_faults(clear_faults),
    .output_on_cmd(output_on_cmd), .oc_detect(oc_detect), .ot_detect(ot_detect),
    .restart_interval_setting(restart_interval_setting), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .bad_command_fault(bad_command_fault),
    .host_attention(host_attention), .output_enable(output_enable),
    .current_limit_active(current_limit_active), .status(status));

  ofr_host_model host (.sys_clk(sys_clk), .cmd_write(cmd_write), .cmd_read(cmd_read),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_byte_count_ok(cmd_byte_count_ok),
    .clear_faults(clear_faults), .output_on_cmd(output_on_cmd));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // bounded wait; running out ends the run
  task automatic wait_oe(input logic v, input int lim);
    int i;
    i = 0;
    while (output_enable !== v && i < lim) begin
      cyc(1);
      i++;
    end
    if (output_enable !== v) begin
      num_errors++;
      $display("[ERR] %0t output enable wait ran out", $time);
      stop_test();
    end
  endtask : wait_oe

  task automatic rd(input logic [7:0] code, input logic [7:0] exp);
    exp_q.push_back(exp);
    host.xfer(1'b0, code, 8'h00, 1'b1);
  endtask : rd

  task automatic clr();
    host.pulse_clear();
    cyc(2);
  endtask : clr

  // read answers matched against the oldest note
  always @(negedge sys_clk) begin
    if (cmd_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(8'h01, 8'h00, "unexpected read answer");
      end else begin
        check(cmd_rdata, exp_q.pop_front(), "read data");
      end
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'hd464;
    rst = 1'b1;
    oc_detect = 1'b0;
    ot_detect = 1'b0;
    restart_interval_setting = 32'd20;
    num_errors = 0;
    checked = 0;
    repeat (6) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rd(OC, 8'h00);
    rd(OT, 8'hc0);
    host.xfer(1'b0, 8'h5a, 8'h00, 1'b1);
    check(8'(status), 8'h00, "status after reset");
    foreach (OT_WR[i]) begin
      host.xfer(1'b1, OT, OT_WR[i], 1'b1);
      cyc(1);
      check(8'(bad_command_fault), 8'h01, "ot write refused");
      rd(OT, 8'hc0);
      clr();
      check(8'(bad_command_fault), 8'h00, "bad command clear");
    end
    for (int i = 0; i < 8; i++) begin
      rnd = 8'($random(seed));
      if (rnd[7:6] == 2'h1) begin
        rnd[7:6] = 2'h3;
      end
      host.xfer(1'b1, OC, rnd, 1'b1);
      rd(OC, rnd);
    end
    host.xfer(1'b1, OC, ~rnd, 1'b0);
    rd(OC, rnd);
    host.xfer(1'b1, OC, 8'h40, 1'b1);
    cyc(1);
    check(8'(bad_command_fault), 8'h01, "oc 01 refused");
    rd(OC, rnd);
    clr();
    $display("test registers done");
    wait_oe(1'b1, 20);
    host.xfer(1'b1, OC, 8'h00, 1'b1);
    oc_detect = 1'b1;
    cyc(3);
    check(8'(status), 8'h3a, "oc status");
    check(8'(host_attention), 8'h01, "oc attention");
    check(8'(current_limit_active), 8'h01, "limiting");
    cyc(50);
    check(8'(output_enable), 8'h01, "keeps running");
    oc_detect = 1'b0;
    cyc(5);
    check(8'(status), 8'h3a, "status sticky");
    check(8'(current_limit_active), 8'h00, "limit released");
    clr();
    check(8'(status), 8'h00, "status cleared");
    check(8'(host_attention), 8'h00, "attention cleared");
    $display("test limit forever done");
    host.xfer(1'b1, OC, 8'hc0, 1'b1);
    oc_detect = 1'b1;
    cyc(2);
    check(8'(output_enable), 8'h00, "shut now");
    oc_detect = 1'b0;
    cyc(30);
    check(8'(output_enable), 8'h00, "no restart");
    host.cycle_on();
    wait_oe(1'b1, 20);
    // status lags the clearing edge by one cycle
    cyc(1);
    check(8'(status), 8'h00, "off-on clears");
    $display("test shut no retry done");
    host.xfer(1'b1, OC, 8'hf8, 1'b1);
    oc_detect = 1'b1;
    cyc(2);
    check(8'(output_enable), 8'h00, "shut before retry");
    oc_detect = 1'b0;
    cyc(10);
    check(8'(output_enable), 8'h00, "interval not elapsed");
    wait_oe(1'b1, 30);
    clr();
    $display("test endless retry done");
    host.xfer(1'b1, OC, 8'h80, 1'b1);
    oc_detect = 1'b1;
    wait_oe(1'b0, 10);
    oc_detect = 1'b0;
    cyc(20);
    check(8'(output_enable), 8'h00, "deglitch off latched");
    host.cycle_on();
    wait_oe(1'b1, 20);
    $display("test deglitch off done");
    ot_detect = 1'b1;
    cyc(3);
    check(8'(status), 8'h25, "ot status");
    check(8'(host_attention), 8'h01, "ot attention");
    cyc(20);
    check(8'(output_enable), 8'h00, "off while hot");
    ot_detect = 1'b0;
    wait_oe(1'b1, 20);
    check(8'(status), 8'h25, "ot sticky");
    clr();
    $display("test overtemp done");
    cyc(2);
    check(8'(exp_q.size()), 8'h00, "reads answered");
    stop_test();
  end
endmodule : tb_top
